// File: rtl/dram_ctl_defines.vh
// timing constants and field layout for the strobe-interface dram controller
`ifndef DRAM_CTL_DEFINES_VH
`define DRAM_CTL_DEFINES_VH
`define CLK_PERIOD_PS        8000
`define ROW_BITS             8
`define COL_BITS             6
`define DATA_BITS            4
`define ROW_COUNT            256
// times in ns (or us / ms where named)
`define RAS_MIN_NS           100
`define RAS_MAX_NS           10000
`define CAS_MIN_NS           60
`define ROW_PRECHARGE_NS     50
`define ROW_TO_COL_NS        15
`define ROW_ACCESS_NS        100
`define COL_ACCESS_NS        60
`define OE_ACCESS_NS         25
`define OE_OFF_NS            20
`define REFRESH_PERIOD_MS    4
`define POWERUP_WAIT_US      500
`define INIT_CYCLES          8
// derived cycle counts: least times round up, longest round down
`define CYC_UP(ns)           ((((ns) * 1000) + `CLK_PERIOD_PS - 1) / `CLK_PERIOD_PS)
`define CYC_DN(ns)           (((ns) * 1000) / `CLK_PERIOD_PS)
`define RAS_MIN_CYC          `CYC_UP(`RAS_MIN_NS)
`define RAS_MAX_CYC          `CYC_DN(`RAS_MAX_NS)
`define CAS_MIN_CYC          `CYC_UP(`CAS_MIN_NS)
`define ROW_PRECHARGE_CYC    `CYC_UP(`ROW_PRECHARGE_NS)
`define ROW_TO_COL_CYC       `CYC_UP(`ROW_TO_COL_NS)
`define ROW_ACCESS_CYC       `CYC_UP(`ROW_ACCESS_NS)
`define COL_ACCESS_CYC       `CYC_UP(`COL_ACCESS_NS)
`define OE_ACCESS_CYC        `CYC_UP(`OE_ACCESS_NS)
`define OE_OFF_CYC           `CYC_UP(`OE_OFF_NS)
`define POWERUP_WAIT_CYC     `CYC_UP(`POWERUP_WAIT_US * 1000)
// refresh interval: 256 rows per period, rounded down so none is late;
// divide by the row count first so the product stays inside 32 bits
`define REFRESH_INTERVAL_CYC `CYC_DN(`REFRESH_PERIOD_MS * 1000000 / `ROW_COUNT)
`endif

// File: rtl/refresh_timer.v
// periodic refresh request timer with sticky pending flag
`timescale 1ns/10ps
module refresh_timer #(
  parameter INTERVAL = 1953
) (
  input  wire clk_i,
  input  wire rst_b_i,
  input  wire ce_i,
  input  wire run_i,
  input  wire taken_i,
  output wire pending_o
);
  reg [15:0] count_reg;
  reg        pending_reg;

  // one request per interval; a new tick wins over a same-cycle take
  always @(posedge clk_i) begin
    if (!rst_b_i) begin
      count_reg   <= 16'h0000;
      pending_reg <= 1'b0;
    end else if (ce_i && run_i) begin
      if (count_reg == INTERVAL[15:0] - 16'h0001) begin
        count_reg   <= 16'h0000;
        pending_reg <= 1'b1;
      end else begin
        count_reg <= count_reg + 16'h0001;
        if (taken_i)
          pending_reg <= 1'b0;
      end
    end
  end

  assign pending_o = pending_reg;
endmodule

// File: rtl/dram_strobe_ctrl.v
// host-side controller driving a 16k x 4 multiplexed-strobe dram
`timescale 1ns/10ps
`include "dram_ctl_defines.vh"
module dram_strobe_ctrl #(
  parameter POWERUP_WAIT = `POWERUP_WAIT_CYC,
  parameter REFRESH_INT  = `REFRESH_INTERVAL_CYC
) (
  input  wire                    clk_i,
  input  wire                    rst_b_i,
  input  wire                    ce_i,
  input  wire                    req_valid_i,
  input  wire                    req_write_i,
  input  wire [13:0]             req_addr_i,
  input  wire [`DATA_BITS-1:0]   req_wdata_i,
  output wire                    req_ready_o,
  output reg                     rsp_valid_o,
  output reg  [`DATA_BITS-1:0]   rsp_rdata_o,
  output wire                    init_done_o,
  output reg                     ras_b_o,
  output reg                     cas_b_o,
  output reg                     we_b_o,
  output reg                     oe_b_o,
  output reg  [`ROW_BITS-1:0]    addr_o,
  output reg  [`DATA_BITS-1:0]   dq_o,
  output reg                     dq_oe_o,
  input  wire [`DATA_BITS-1:0]   dq_i
);
  localparam S_POWERUP = 3'h0;
  localparam S_IDLE    = 3'h1;
  localparam S_ROW     = 3'h2;
  localparam S_COL     = 3'h3;
  localparam S_CBR     = 3'h4;
  localparam S_CBR_RAS = 3'h5;
  localparam S_PRECHG  = 3'h6;

  // read sample point must cover row access and column access after cas
  localparam RD_WAIT = (`ROW_ACCESS_CYC > `ROW_TO_COL_CYC + `COL_ACCESS_CYC) ?
                       `ROW_ACCESS_CYC - `ROW_TO_COL_CYC : `COL_ACCESS_CYC;
  localparam COL_HOLD = (RD_WAIT + 1 > `CAS_MIN_CYC) ? RD_WAIT + 1 : `CAS_MIN_CYC;
  // init cycle count at the width of its down counter
  localparam [3:0] INIT_LEFT = `INIT_CYCLES;

  // timer counts down to one; zero means no wait is pending
  reg [2:0]  state_reg;
  reg [19:0] timer_reg;
  reg [3:0]  init_left_reg;
  reg        init_done_reg;
  reg        is_write_reg;
  reg [13:0] addr_reg;
  reg [`DATA_BITS-1:0] wdata_reg;
  wire       refresh_pending;
  wire       refresh_taken;

  // narrows an integer cycle count to the timer width
  function [19:0] cyc20;
    input integer n;
    begin
      cyc20 = n[19:0];
    end
  endfunction

  // ticks start once init is done, so init cycles are not counted twice
  refresh_timer #(
    .INTERVAL (REFRESH_INT)
  ) u_refresh_timer (
    .clk_i     (clk_i),
    .rst_b_i   (rst_b_i),
    .ce_i      (ce_i),
    .run_i     (init_done_reg),
    .taken_i   (refresh_taken),
    .pending_o (refresh_pending)
  );

  // refresh takes priority over a waiting request
  assign refresh_taken = (state_reg == S_IDLE) && refresh_pending && ce_i;
  // ready drops while frozen so a request is never reported taken then lost
  assign req_ready_o   = (state_reg == S_IDLE) && init_done_reg && !refresh_pending && ce_i;
  assign init_done_o   = init_done_reg;

  // main strobe sequencer
  always @(posedge clk_i) begin
    if (!rst_b_i) begin
      state_reg     <= S_POWERUP;
      timer_reg     <= 20'h00000;
      init_left_reg <= 4'h0;
      init_done_reg <= 1'b0;
      is_write_reg  <= 1'b0;
      addr_reg      <= 14'h0000;
      wdata_reg     <= 4'h0;
      ras_b_o       <= 1'b1;
      cas_b_o       <= 1'b1;
      we_b_o        <= 1'b1;
      oe_b_o        <= 1'b1;
      addr_o        <= 8'h00;
      dq_o          <= 4'h0;
      dq_oe_o       <= 1'b0;
      rsp_valid_o   <= 1'b0;
      rsp_rdata_o   <= 4'h0;
    end else if (ce_i) begin
      rsp_valid_o <= 1'b0;
      if (timer_reg != 20'h00000)
        timer_reg <= timer_reg - 20'h00001;
      case (state_reg)
        // power-up pause, then eight cbr cycles as init
        S_POWERUP: begin
          if (timer_reg == cyc20(1) || POWERUP_WAIT <= 1) begin
            init_left_reg <= INIT_LEFT;
            state_reg     <= S_IDLE;
            timer_reg     <= 20'h00000;
          end else if (timer_reg == 20'h00000) begin
            timer_reg <= cyc20(POWERUP_WAIT);
          end
        end
        S_IDLE: begin
          // refresh and init cycles go before any waiting request
          if (init_left_reg != 4'h0 || refresh_pending) begin
            // cas falls first: internal counter row, no selection
            cas_b_o   <= 1'b0;
            oe_b_o    <= 1'b1; // no read output is held over a refresh
            dq_oe_o   <= 1'b0;
            timer_reg <= cyc20(1);
            state_reg <= S_CBR;
          end else if (req_valid_i && init_done_reg) begin
            is_write_reg <= req_write_i;
            addr_reg     <= req_addr_i;
            wdata_reg    <= req_wdata_i;
            // row address on all eight pins with cas high
            addr_o       <= req_addr_i[13:6];
            ras_b_o      <= 1'b0;
            we_b_o       <= !req_write_i; // early write set before cas
            oe_b_o       <= 1'b1;
            dq_o         <= req_wdata_i;
            dq_oe_o      <= req_write_i; // released for reads
            timer_reg    <= cyc20(`ROW_TO_COL_CYC);
            state_reg    <= S_ROW;
          end
        end
        S_ROW: begin
          // column bits sit on pins one to six
          addr_o <= {1'b0, addr_reg[5:0], 1'b0};
          if (timer_reg <= cyc20(1)) begin
            cas_b_o   <= 1'b0; // overlapped row-then-column
            oe_b_o    <= is_write_reg; // read: oe low, we high
            timer_reg <= cyc20(COL_HOLD);
            state_reg <= S_COL;
          end
        end
        S_COL: begin
          // sample after row, column and oe access times
          if (!is_write_reg && timer_reg == cyc20(COL_HOLD - RD_WAIT))
            rsp_rdata_o <= dq_i;
          // both strobes and oe rise together at the end of the access
          if (timer_reg <= cyc20(1) && timer_reg >= cyc20(0)) begin
            if (timer_reg == cyc20(1) || timer_reg == 20'h00000) begin
              ras_b_o     <= 1'b1;
              cas_b_o     <= 1'b1;
              oe_b_o      <= 1'b1; // turn output off, no hold-over
              we_b_o      <= 1'b1;
              dq_oe_o     <= 1'b0;
              rsp_valid_o <= 1'b1;
              // extra cycles let the read buffer turn off before pins turn round
              timer_reg   <= cyc20(`ROW_PRECHARGE_CYC + `OE_OFF_CYC);
              state_reg   <= S_PRECHG;
            end
          end
        end
        S_CBR: begin
          // cas leads ras by one cycle, so the internal counter row is used
          if (timer_reg <= cyc20(1)) begin
            ras_b_o   <= 1'b0;
            timer_reg <= cyc20(`RAS_MIN_CYC);
            state_reg <= S_CBR_RAS;
          end
        end
        S_CBR_RAS: begin
          // ras low within 10k ns limit, cbr needs no address
          if (timer_reg <= cyc20(1)) begin
            ras_b_o   <= 1'b1;
            cas_b_o   <= 1'b1;
            timer_reg <= cyc20(`ROW_PRECHARGE_CYC);
            if (init_left_reg != 4'h0) begin
              init_left_reg <= init_left_reg - 4'h1;
              if (init_left_reg == 4'h1)
                init_done_reg <= 1'b1;
            end
            state_reg <= S_PRECHG;
          end
        end
        S_PRECHG: begin
          // ras high for full precharge before the next cycle
          if (timer_reg <= cyc20(1))
            state_reg <= S_IDLE;
        end
        // unused codes fall back to idle rather than hang
        default: begin
          state_reg <= S_IDLE;
        end
      endcase
    end
  end
endmodule

// File: test/dram_strobe_ctrl_props.sv
// pin assertions for the dram controller
`timescale 1ns/10ps
module dram_strobe_ctrl_props #(parameter REFRESH_INT = 64) (
  input wire        clk_i,
  input wire        rst_b_i,
  input wire        req_valid_i,
  input wire        req_ready_o,
  input wire [13:0] req_addr_i,
  input wire        init_done_o,
  input wire        ras_b_o,
  input wire        cas_b_o,
  input wire        we_b_o,
  input wire        oe_b_o,
  input wire [7:0]  addr_o,
  input wire        dq_oe_o
);
  reg [10:0] lo_n;
  reg [8:0]  gap;
  reg [3:0]  ras_n;
  // row low time, refresh gap, row strobes since reset
  always @(posedge clk_i) begin
    lo_n <= ras_b_o ? 11'h000 : lo_n + 11'h001;
    gap <= (!rst_b_i || ($fell(ras_b_o) && !cas_b_o)) ? 9'h000 : gap + 9'h001;
    ras_n <= !rst_b_i ? 4'h0 : ras_n + {3'h0, $fell(ras_b_o) && ras_n != 4'hF};
  end
  default clocking @(posedge clk_i); endclocking
  default disable iff (!rst_b_i);
  property p_row; req_valid_i && req_ready_o |=> $fell(ras_b_o) && cas_b_o
    && addr_o == $past(req_addr_i[13:6]); endproperty
  a_row: assert property (p_row) else $error("row addr");
  property p_col; req_valid_i && req_ready_o |=> ##1
    addr_o == {1'b0, $past(req_addr_i[5:0], 2), 1'b0} ##1 !cas_b_o && !ras_b_o; endproperty
  a_col: assert property (p_col) else $error("col addr");
  property p_pre; $rose(ras_b_o) |-> ras_b_o[*7]; endproperty
  a_pre: assert property (p_pre) else $error("precharge");
  property p_wid; $rose(ras_b_o) |-> lo_n >= 11'h00D && lo_n <= 11'h4E2; endproperty
  a_wid: assert property (p_wid) else $error("row width");
  property p_rd; !oe_b_o |-> we_b_o && !dq_oe_o; endproperty
  a_rd: assert property (p_rd) else $error("read pins");
  property p_ew; $fell(cas_b_o) && !we_b_o |-> !$past(we_b_o) && oe_b_o && dq_oe_o; endproperty
  a_ew: assert property (p_ew) else $error("early write");
  property p_cbr; $fell(ras_b_o) && !cas_b_o |-> oe_b_o && we_b_o && !dq_oe_o; endproperty
  a_cbr: assert property (p_cbr) else $error("refresh");
  property p_ref; init_done_o |-> gap < REFRESH_INT + 48; endproperty
  a_ref: assert property (p_ref) else $error("refresh gap");
  property p_ini; $rose(init_done_o) |-> ras_n >= 4'h8; endproperty
  a_ini: assert property (p_ini) else $error("init cycles");
endmodule
bind dram_strobe_ctrl dram_strobe_ctrl_props #(.REFRESH_INT(REFRESH_INT)) u_props (
  .clk_i(clk_i), .rst_b_i(rst_b_i), .req_valid_i(req_valid_i), .req_ready_o(req_ready_o),
  .req_addr_i(req_addr_i), .init_done_o(init_done_o), .ras_b_o(ras_b_o), .cas_b_o(cas_b_o),
  .we_b_o(we_b_o), .oe_b_o(oe_b_o), .addr_o(addr_o), .dq_oe_o(dq_oe_o));

// File: test/dram_dev_model.sv
// behavioural 16k x 4 strobe dram
`timescale 1ns/10ps
module dram_dev_model #(parameter T_ROW = 100, T_COL = 60, T_OE = 25) (
  input  wire       ras_b_i,
  input  wire       cas_b_i,
  input  wire       we_b_i,
  input  wire       oe_b_i,
  input  wire [7:0] addr_i,
  input  wire [3:0] wd_i,
  input  wire       wd_en_i,
  output wire [3:0] dq_o
);
  reg [3:0] mem [0:16383];
  reg [7:0] row, rcnt = 8'h00;
  reg [5:0] col;
  reg [3:0] last = 4'h5;
  reg       acc, sel = 1'b0, on = 1'b0;
  realtime  tr, tc, to;
  // cas high opens the addressed row, else internal counter row
  // pins are read just after the edge, clear of the launch race
  always @(negedge ras_b_i) begin
    tr = $realtime;
    #1;
    acc = cas_b_i;
    if (acc) begin
      row = addr_i;
    end else
      rcnt = rcnt + 8'h01;
  end
  // column counts only inside an overlapped access
  always @(negedge cas_b_i) begin
    tc = $realtime;
    if (!ras_b_i && acc) begin
      col = addr_i[6:1];
      if (!we_b_i)
        mem[{row, col}] = wd_i;
      sel = we_b_i;
    end
  end
  always @(negedge oe_b_i) to = $realtime;
  // oe alone cannot revive the buffer
  always @(posedge cas_b_i or posedge oe_b_i) sel = 1'b0;
  // ras rising is ignored, so data holds while cas and oe stay low
  always #1 begin
    on = sel && !cas_b_i && !oe_b_i && $realtime >= tr + T_ROW
      && $realtime >= tc + T_COL && $realtime >= to + T_OE;
    if (on)
      last = mem[{row, col}];
  end
  // no pull on the bus: a released line shows the inverse
  assign dq_o = wd_en_i ? wd_i : on ? last : ~last;
endmodule

// File: test/dram_strobe_ctrl_tb_top.sv
// self-checking bench for the dram controller
`timescale 1ns/10ps
module dram_strobe_ctrl_tb_top;
  reg        clk_i, rst_b_i, ce_i, req_valid_i, req_write_i;
  reg [13:0] req_addr_i;
  reg [3:0]  req_wdata_i;
  wire       req_ready_o, rsp_valid_o, init_done_o, ras_b_o, cas_b_o, we_b_o, oe_b_o, dq_oe_o;
  wire [3:0] rsp_rdata_o, dq_o, dq_i;
  wire [7:0] addr_o;
  reg [3:0]  shadow [0:7];
  reg [13:0] alist [0:7];
  reg [4:0]  expq [$];
  reg [4:0]  e;
  reg [31:0] seed;
  integer    n_fail, cmp_count, i, k;
  dram_strobe_ctrl #(.POWERUP_WAIT(4), .REFRESH_INT(64)) dut (.clk_i(clk_i), .rst_b_i(rst_b_i),
    .ce_i(ce_i), .req_valid_i(req_valid_i), .req_write_i(req_write_i), .req_addr_i(req_addr_i),
    .req_wdata_i(req_wdata_i), .req_ready_o(req_ready_o), .rsp_valid_o(rsp_valid_o),
    .rsp_rdata_o(rsp_rdata_o), .init_done_o(init_done_o), .ras_b_o(ras_b_o), .cas_b_o(cas_b_o),
    .we_b_o(we_b_o), .oe_b_o(oe_b_o), .addr_o(addr_o), .dq_o(dq_o), .dq_oe_o(dq_oe_o), .dq_i(dq_i));
  dram_dev_model u_dev (.ras_b_i(ras_b_o), .cas_b_i(cas_b_o), .we_b_i(we_b_o), .oe_b_i(oe_b_o),
    .addr_i(addr_o), .wd_i(dq_o), .wd_en_i(dq_oe_o), .dq_o(dq_i));
  function [31:0] rnd(input [31:0] s);
    rnd = s ^ (s << 13);
    rnd = rnd ^ (rnd >> 17);
    rnd = rnd ^ (rnd << 5);
  endfunction
  task chk(input [63:0] nm, input [3:0] x, input [3:0] g);
    cmp_count = cmp_count + 1;
    if (x !== g) begin
      n_fail = n_fail + 1;
      $display("[ERR] %0s exp %h got %h", nm, x, g);
    end
  endtask
  task test_done;
    $display("compares %0d mismatches %0d", cmp_count, n_fail);
    if (n_fail == 0 && cmp_count > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask
  // hold the request until ready, note the result at the take
  task op(input w, input [2:0] j);
    @(negedge clk_i);
    seed = rnd(seed);
    req_valid_i = 1'b1;
    req_write_i = w;
    req_addr_i = alist[j];
    req_wdata_i = seed[3:0];
    for (k = 0; k < 200 && req_ready_o !== 1'b1; k = k + 1)
      @(negedge clk_i);
    if (k == 200) begin
      n_fail = n_fail + 1;
      test_done;
    end
    // now and then freeze one idle cycle; the take must wait for ce
    if (seed[7]) begin
      ce_i = 1'b0;
      @(negedge clk_i);
      ce_i = 1'b1;
    end
    @(posedge clk_i);
    if (w)
      shadow[j] = seed[3:0];
    expq.push_back({!w, shadow[j]});
  endtask
  initial begin
    clk_i = 1'b0;
    forever #4 clk_i = ~clk_i;
  end
  // responses pulse one cycle, so the falling edge sees each once
  always @(negedge clk_i)
    if (rst_b_i && rsp_valid_o === 1'b1) begin
      if (expq.size() == 0) begin
        n_fail = n_fail + 1;
        $display("[ERR] rsp_valid exp 0 got 1");
      end else begin
        e = expq.pop_front();
        if (e[4])
          chk("rdata", e[3:0], rsp_rdata_o);
      end
    end
  initial begin
    seed = 32'h3C711A43;
    {n_fail, cmp_count} = 0;
    {rst_b_i, req_valid_i, req_write_i, req_addr_i, req_wdata_i} = 0;
    ce_i = 1'b1;
    for (i = 0; i < 8; i = i + 1) begin
      seed = rnd(seed);
      alist[i] = {seed[13:3], i[2:0]};
    end
    alist[0] = 14'h0000;
    alist[7] = 14'h3FFF;
    repeat (20) @(negedge clk_i);
    rst_b_i = 1'b1;
    for (k = 0; k < 2000 && init_done_o !== 1'b1; k = k + 1)
      @(negedge clk_i);
    if (k == 2000) begin
      n_fail = n_fail + 1;
      test_done;
    end
    // fill every slot, then a random back-to-back mix across refreshes
    for (i = 0; i < 8; i = i + 1)
      op(1'b1, i[2:0]);
    for (i = 0; i < 150; i = i + 1) begin
      seed = rnd(seed);
      op(seed[8], seed[2:0]);
    end
    @(negedge clk_i);
    req_valid_i = 1'b0;
    for (k = 0; k < 100 && expq.size() > 0; k = k + 1)
      @(negedge clk_i);
    if (expq.size() > 0 || init_done_o !== 1'b1)
      n_fail = n_fail + 1;
    test_done;
  end
endmodule
